/* verilog/adcsc_top.sv */
// Sample and conversion start sequencing with AXI4-Lite registers and one interrupt.
//
// Register access over AXI4-Lite and the register offsets were decided locally.
`timescale 1ns/1ps
module adcsc_top
    import adcsc_pkg::*;
(
    input  wire logic        CORE_CLK,
    input  wire logic        RST_N,
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [7:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    input  wire logic [2:0]  PWM_GEN_TRIG,
    input  wire logic        PWM_SPECIAL_TRIG,
    input  wire logic        THIRD_TIMER_CMP,
    input  wire logic        FIFTH_TIMER_CMP,
    input  wire logic        CHARGE_TIME_EVT,
    input  wire logic        EXT_INT_ZERO,
    input  wire logic        EXT_INT_ZERO_FALL,
    output logic             SAMPLE_HOLD_SAMPLING,
    output logic [3:0]       CHANNEL_SAMPLE_EN,
    output logic             CONV_START,
    output logic             IRQ
);
    ////////////////////////////////////////////////////////////////////////////////
    // Synchronisers for every trigger, since the sources run off other logic or pins.
    logic [8:0] trig_s1_q;
    logic [8:0] trig_s2_q;
    logic [8:0] trig_s3_q;
    wire  [8:0] trig_raw = {EXT_INT_ZERO_FALL, EXT_INT_ZERO, CHARGE_TIME_EVT, FIFTH_TIMER_CMP,
                            THIRD_TIMER_CMP, PWM_SPECIAL_TRIG, PWM_GEN_TRIG};
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            trig_s1_q <= 9'h000;
            trig_s2_q <= 9'h000;
            trig_s3_q <= 9'h000;
        end else begin
            trig_s1_q <= trig_raw;
            trig_s2_q <= trig_s1_q;
            trig_s3_q <= trig_s2_q;
        end
    end
    wire [8:0] trig_rise = trig_s2_q & ~trig_s3_q;
    wire [8:0] trig_fall = ~trig_s2_q & trig_s3_q;
    wire       int0_edge = trig_s2_q[8] ? trig_fall[7] : trig_rise[7];

    ////////////////////////////////////////////////////////////////////////////////
    // Control registers.
    logic [2:0]   src_q;
    logic         group_q;
    logic         simul_q;
    logic         auto_q;
    logic         sample_q;
    logic         done_q;
    logic         twelve_q;
    logic [1:0]   chcnt_q;
    logic [1:0]   irq_stat_q;
    logic [1:0]   irq_mask_q;
    adcsc_state_e state_q;
    logic [7:0]   cnt_q;

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave: address and data are caught in either order, one of each at a time.
    logic        aw_have_q;
    logic        w_have_q;
    logic [7:0]  awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    wire aw_fire  = S_AXI_AWVALID && S_AXI_AWREADY;
    wire w_fire   = S_AXI_WVALID && S_AXI_WREADY;
    wire wr_go    = aw_have_q && w_have_q && !S_AXI_BVALID;
    wire wr_ctrl  = wr_go && awaddr_q == ADCSC_OFF_CTRL1;
    wire wr_cfg   = wr_go && awaddr_q == ADCSC_OFF_CFG;
    wire wr_stat  = wr_go && awaddr_q == ADCSC_OFF_IRQ_STAT;
    wire wr_mask  = wr_go && awaddr_q == ADCSC_OFF_IRQ_MASK;
    wire wr_hit   = wr_ctrl || wr_cfg || wr_stat || wr_mask;
    wire lo_en    = wstrb_q[0];
    wire simul_ok = !twelve_q && chcnt_q != 2'h0;
    wire simul_rd = simul_q && !twelve_q;
    wire [15:0] ctrl_rd = {8'h00, src_q, group_q, simul_rd, auto_q, sample_q, done_q};
    wire ar_fire  = S_AXI_ARVALID && S_AXI_ARREADY;
    wire rd_hit   = S_AXI_ARADDR == ADCSC_OFF_CTRL1 || S_AXI_ARADDR == ADCSC_OFF_CFG
                 || S_AXI_ARADDR == ADCSC_OFF_IRQ_STAT || S_AXI_ARADDR == ADCSC_OFF_IRQ_MASK;
    wire [31:0] rd_mux =
        (S_AXI_ARADDR == ADCSC_OFF_CTRL1)    ? {16'h0000, ctrl_rd} :
        (S_AXI_ARADDR == ADCSC_OFF_CFG)      ? {29'h0, chcnt_q, twelve_q} :
        (S_AXI_ARADDR == ADCSC_OFF_IRQ_STAT) ? {30'h0, irq_stat_q} :
        (S_AXI_ARADDR == ADCSC_OFF_IRQ_MASK) ? {30'h0, irq_mask_q} : 32'h0000_0000;

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            awaddr_q      <= 8'h00;
            wdata_q       <= 32'h0000_0000;
            wstrb_q       <= 4'h0;
            S_AXI_AWREADY <= 1'b1;
            S_AXI_WREADY  <= 1'b1;
            S_AXI_BVALID  <= 1'b0;
            S_AXI_BRESP   <= ADCSC_RESP_OKAY;
            S_AXI_ARREADY <= 1'b1;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= 32'h0000_0000;
            S_AXI_RRESP   <= ADCSC_RESP_OKAY;
        end else begin
            if (aw_fire) begin
                aw_have_q     <= 1'b1;
                awaddr_q      <= S_AXI_AWADDR;
                S_AXI_AWREADY <= 1'b0;
            end
            if (w_fire) begin
                w_have_q     <= 1'b1;
                wdata_q      <= S_AXI_WDATA;
                wstrb_q      <= S_AXI_WSTRB;
                S_AXI_WREADY <= 1'b0;
            end
            if (wr_go) begin
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= wr_hit ? ADCSC_RESP_OKAY : ADCSC_RESP_SLVERR;
            end
            if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID  <= 1'b0;
                S_AXI_AWREADY <= 1'b1;
                S_AXI_WREADY  <= 1'b1;
            end
            if (ar_fire) begin
                S_AXI_ARREADY <= 1'b0;
                S_AXI_RVALID  <= 1'b1;
                S_AXI_RDATA   <= rd_mux;
                S_AXI_RRESP   <= rd_hit ? ADCSC_RESP_OKAY : ADCSC_RESP_SLVERR;
            end
            if (S_AXI_RVALID && S_AXI_RREADY) begin
                S_AXI_RVALID  <= 1'b0;
                S_AXI_ARREADY <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Trigger selection; reserved codes select nothing and so never end sampling.
    logic trig_sel;
    always_comb begin
        trig_sel = 1'b0;
        if (group_q) begin
            case (src_q)
                3'h0:    trig_sel = trig_rise[0];
                3'h1:    trig_sel = trig_rise[1];
                3'h2:    trig_sel = trig_rise[2];
                default: trig_sel = 1'b0;
            endcase
        end else begin
            case (src_q)
                ADCSC_SRC_AUTO:   trig_sel = cnt_q == 8'h00;
                ADCSC_SRC_CHARGE: trig_sel = trig_rise[6];
                ADCSC_SRC_TMR5:   trig_sel = trig_rise[5];
                ADCSC_SRC_TMR3:   trig_sel = trig_rise[4];
                ADCSC_SRC_PWMSEV: trig_sel = trig_rise[3];
                ADCSC_SRC_EXTINT: trig_sel = int0_edge;
                default:          trig_sel = 1'b0;
            endcase
        end
    end

    wire manual     = !group_q && src_q == ADCSC_SRC_MANUAL;
    wire sw_sample_enable_bit_1  = wr_ctrl && lo_en && wdata_q[ADCSC_BIT_SAMPLE];
    wire sw_sample_enable_bit_0  = wr_ctrl && lo_en && !wdata_q[ADCSC_BIT_SAMPLE];
    wire sampling   = state_q == ADCSC_ST_SAMPLE;
    wire hold_go    = sampling && (manual ? sw_sample_enable_bit_0 : trig_sel);
    wire conv_end   = state_q == ADCSC_ST_CONV && cnt_q == 8'h00;
    wire start_sample_enable_bit = (state_q == ADCSC_ST_IDLE && sw_sample_enable_bit_1 && !auto_q)
                   || (conv_end && auto_q);

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer and control register updates.
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            state_q    <= ADCSC_ST_IDLE;
            cnt_q      <= 8'h00;
            {src_q, group_q, simul_q, auto_q} <= ADCSC_RST_CTRL1[7:2];
            sample_q   <= 1'b0;
            done_q     <= 1'b0;
            {chcnt_q, twelve_q} <= ADCSC_RST_CFG;
            irq_stat_q <= ADCSC_RST_IRQ;
            irq_mask_q <= ADCSC_RST_IRQ;
            CONV_START <= 1'b0;
        end else begin
            if (wr_ctrl && lo_en) begin
                src_q   <= wdata_q[ADCSC_POS_SRC +: 3];
                group_q <= wdata_q[ADCSC_BIT_GROUP];
                simul_q <= wdata_q[ADCSC_BIT_SIMUL];
                auto_q  <= wdata_q[ADCSC_BIT_AUTO];
            end
            if (wr_cfg && lo_en) begin
                twelve_q <= wdata_q[ADCSC_BIT_TWELVE];
                chcnt_q  <= wdata_q[ADCSC_POS_CHCNT +: 2];
            end
            if (wr_mask && lo_en) begin
                irq_mask_q <= wdata_q[1:0];
            end
            CONV_START <= hold_go;
            case (state_q)
                ADCSC_ST_IDLE: begin
                    if (start_sample_enable_bit) begin
                        state_q  <= ADCSC_ST_SAMPLE;
                        sample_q <= 1'b1;
                        cnt_q    <= ADCSC_AUTO_CYC;
                    end
                end
                ADCSC_ST_SAMPLE: begin
                    if (cnt_q != 8'h00) begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                    if (hold_go) begin
                        state_q  <= ADCSC_ST_CONV;
                        sample_q <= 1'b0;
                        cnt_q    <= ADCSC_CONV_CYC;
                    end
                end
                ADCSC_ST_CONV: begin
                    if (conv_end) begin
                        state_q  <= auto_q ? ADCSC_ST_SAMPLE : ADCSC_ST_IDLE;
                        sample_q <= auto_q;
                        cnt_q    <= ADCSC_AUTO_CYC;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                default: begin
                    state_q <= ADCSC_ST_IDLE;
                end
            endcase
            // Completion sets done and beats a simultaneous software clear.
            if (hold_go) begin
                done_q <= 1'b0;
            end else if (conv_end) begin
                done_q <= 1'b1;
            end else if (wr_ctrl && lo_en && !wdata_q[ADCSC_BIT_DONE]) begin
                done_q <= 1'b0;
            end
            irq_stat_q <= (irq_stat_q & ~((wr_stat && lo_en) ? wdata_q[1:0] : 2'h0))
                        | {hold_go, conv_end};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs, all registered.
    wire [3:0] ch_en_d = !sampling ? 4'h0 :
                         (!simul_ok || !simul_q) ? 4'h1 :
                         chcnt_q[1] ? 4'hF : 4'h3;
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            SAMPLE_HOLD_SAMPLING <= 1'b0;
            CHANNEL_SAMPLE_EN    <= 4'h0;
            IRQ                  <= 1'b0;
        end else begin
            SAMPLE_HOLD_SAMPLING <= sampling;
            CHANNEL_SAMPLE_EN    <= ch_en_d;
            IRQ                  <= |(irq_stat_q & irq_mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.
    a_done_on_end: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        conv_end |=> done_q) else $error("done not set at conversion end");
    a_done_clr_start: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        hold_go |=> !done_q) else $error("done not cleared at conversion start");
    a_hw_clear_sample: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (sampling && !manual && trig_sel) |=> !sample_q ##1 !SAMPLE_HOLD_SAMPLING)
        else $error("sample bit not cleared by trigger");
    a_manual_sw_end: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (sampling && manual && sw_sample_enable_bit_0) |=> CONV_START) else $error("manual end missed");
    a_auto_restart: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (conv_end && auto_q) |=> sample_q) else $error("auto-sample did not restart");
    a_no_auto_idle: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (state_q == ADCSC_ST_IDLE && !sw_sample_enable_bit_1) |=> !sample_q)
        else $error("sampling began without software");
    a_reserved_hold: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (sampling && group_q && src_q > 3'h2) |=> sampling) else $error("reserved code fired");
    a_twelve_simul: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        twelve_q |-> !ctrl_rd[ADCSC_BIT_SIMUL]) else $error("simultaneous bit visible");
    a_simul_four: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (sampling && simul_q && !twelve_q && chcnt_q[1]) |=> CHANNEL_SAMPLE_EN == 4'hF)
        else $error("four channels not sampled together");
    a_sample_state: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        sample_q == sampling) else $error("sample bit disagrees with state");
    c_manual_conv: cover property (@(posedge CORE_CLK) disable iff (!RST_N)
        sampling && manual ##1 CONV_START);
    c_auto_loop: cover property (@(posedge CORE_CLK) disable iff (!RST_N)
        conv_end && auto_q);
    c_pwm_trig: cover property (@(posedge CORE_CLK) disable iff (!RST_N)
        hold_go && group_q);
    c_irq: cover property (@(posedge CORE_CLK) disable iff (!RST_N) IRQ);
endmodule

/* verilog/adcsc_pkg.sv */
// Package of register map, field positions, reset values and timing counts for the sampling control.
package adcsc_pkg;
    localparam logic [7:0]  ADCSC_OFF_CTRL1    = 8'h00;
    localparam logic [7:0]  ADCSC_OFF_CFG      = 8'h04;
    localparam logic [7:0]  ADCSC_OFF_IRQ_STAT = 8'h08;
    localparam logic [7:0]  ADCSC_OFF_IRQ_MASK = 8'h0C;
    localparam int          ADCSC_BIT_DONE     = 0;
    localparam int          ADCSC_BIT_SAMPLE   = 1;
    localparam int          ADCSC_BIT_AUTO     = 2;
    localparam int          ADCSC_BIT_SIMUL    = 3;
    localparam int          ADCSC_BIT_GROUP    = 4;
    localparam int          ADCSC_POS_SRC      = 5;
    localparam int          ADCSC_BIT_TWELVE   = 0;
    localparam int          ADCSC_POS_CHCNT    = 1;
    localparam int          ADCSC_IRQ_DONE     = 0;
    localparam int          ADCSC_IRQ_TRIG     = 1;
    localparam logic [15:0] ADCSC_RST_CTRL1    = 16'h0000;
    localparam logic [2:0]  ADCSC_RST_CFG      = 3'h0;
    localparam logic [1:0]  ADCSC_RST_IRQ      = 2'h0;
    localparam int          ADCSC_CLK_MHZ      = 250;
    localparam int          ADCSC_CONV_NS      = 240;
    localparam int          ADCSC_AUTO_NS      = 128;
    localparam logic [7:0]  ADCSC_CONV_CYC     = 8'((ADCSC_CONV_NS * ADCSC_CLK_MHZ) / 1000);
    localparam logic [7:0]  ADCSC_AUTO_CYC     = 8'((ADCSC_AUTO_NS * ADCSC_CLK_MHZ) / 1000);
    localparam logic [2:0]  ADCSC_SRC_MANUAL   = 3'h0;
    localparam logic [2:0]  ADCSC_SRC_EXTINT   = 3'h1;
    localparam logic [2:0]  ADCSC_SRC_TMR3     = 3'h2;
    localparam logic [2:0]  ADCSC_SRC_PWMSEV   = 3'h3;
    localparam logic [2:0]  ADCSC_SRC_TMR5     = 3'h4;
    localparam logic [2:0]  ADCSC_SRC_CHARGE   = 3'h6;
    localparam logic [2:0]  ADCSC_SRC_AUTO     = 3'h7;
    localparam logic [1:0]  ADCSC_RESP_OKAY    = 2'h0;
    localparam logic [1:0]  ADCSC_RESP_SLVERR  = 2'h2;
    typedef enum logic [2:0] {
        ADCSC_ST_IDLE   = 3'b001,
        ADCSC_ST_SAMPLE = 3'b010,
        ADCSC_ST_CONV   = 3'b100
    } adcsc_state_e;
endpackage

/* test/adcsc_trig_model.sv */
// Model of the on-chip trigger sources that feed the sampling control.
`timescale 1ns/1ps
module adcsc_trig_model (
    input  wire logic       clk,
    input  wire logic [7:0] req,
    output logic      [7:0] line
);
    logic [7:0] h1_q = 8'h00;
    logic [7:0] h2_q = 8'h00;
    logic [7:0] h3_q = 8'h00;
    ////////////////////////////////////////////////////////////////////////////////
    // A request becomes three cycles high, so the two-flop synchroniser sees one clean edge.
    always_ff @(posedge clk) begin
        h1_q <= req;
        h2_q <= h1_q;
        h3_q <= h2_q;
    end
    // Lines idle low between events, as the real sources do.
    assign line = h1_q | h2_q | h3_q;
endmodule

/* test/adcsc_top_tb.sv */
// Self-checking testbench of the sampling and conversion start control.
`timescale 1ns/1ps
module adcsc_top_tb;
    import adcsc_pkg::*;
    logic        core_clk = 1'b0, rst_n = 1'b0, ext_fall = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, trig_req = 8'h00, trig_line;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [3:0]  wstrb = 4'hF, ch_en;
    logic [1:0]  bresp, rresp, resp;
    logic        awready, wready, bvalid, arready, rvalid, sampling, conv_start, irq, seen;
    logic [3:0]  cd [8] = '{4'h8, 4'h9, 4'hA, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6};
    int          ln [8] = '{0, 1, 2, 7, 4, 3, 5, 6};
    logic [3:0]  rsv [6] = '{4'hB, 4'hC, 4'hD, 4'hE, 4'hF, 4'h5};
    int          fail_count = 0, checks_done = 0, cycles = 0, starts = 0, base = 0;
    ////////////////////////////////////////////////////////////////////////////////
    adcsc_top i_adcsc_top (
        .CORE_CLK(core_clk), .RST_N(rst_n),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .PWM_GEN_TRIG(trig_line[2:0]), .PWM_SPECIAL_TRIG(trig_line[3]),
        .THIRD_TIMER_CMP(trig_line[4]), .FIFTH_TIMER_CMP(trig_line[5]),
        .CHARGE_TIME_EVT(trig_line[6]), .EXT_INT_ZERO(trig_line[7]),
        .EXT_INT_ZERO_FALL(ext_fall), .SAMPLE_HOLD_SAMPLING(sampling),
        .CHANNEL_SAMPLE_EN(ch_en), .CONV_START(conv_start), .IRQ(irq)
    );
    adcsc_trig_model i_adcsc_trig_model (.clk(core_clk), .req(trig_req), .line(trig_line));
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #2 core_clk = ~core_clk;
    end
    // The start pulse lasts one cycle and may fall inside a bus task, so it is counted here.
    always @(posedge core_clk) begin
        if (conv_start === 1'b1) starts <= starts + 1;
    end
    // The whole run needs some two and a half thousand cycles; a hang is cut off well beyond that.
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 12000) begin
            fail_count++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", nm, exp, got);
            fail_count++;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Bus tasks start right after an edge and end one edge after the answer, so
    // no strobe is ever assigned twice in one time step.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rdreg(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic wait_start(input int lim);
        repeat (lim) begin
            @(posedge core_clk);
        end
        seen = (starts != base);
        base = starts;
    endtask
    task automatic fire(input logic [7:0] m);
        base = starts;
        trig_req <= m;
        @(posedge core_clk);
        trig_req <= 8'h00;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rdreg(ADCSC_OFF_CTRL1);
        chk("control reset", {16'h0000, ADCSC_RST_CTRL1}, rd);
        rdreg(ADCSC_OFF_CFG);
        chk("config reset", {29'h0, ADCSC_RST_CFG}, rd);
        rdreg(ADCSC_OFF_IRQ_STAT);
        chk("status reset", {30'h0, ADCSC_RST_IRQ}, rd);
        rdreg(8'h10);
        chk("unmapped read", {30'h0, ADCSC_RESP_SLVERR}, {30'h0, resp});
        wr(8'h10, 32'hFF);
        chk("unmapped write", {30'h0, ADCSC_RESP_SLVERR}, {30'h0, resp});
        $display("test registers finished");
    endtask
    task automatic t_manual();
        wr(ADCSC_OFF_CTRL1, 32'h2);
        repeat (3) @(posedge core_clk);
        chk("sampling", 32'h1, {31'h0, sampling});
        rdreg(ADCSC_OFF_CTRL1);
        chk("sample bit set", 32'h2, rd);
        base = starts;
        wr(ADCSC_OFF_CTRL1, 32'h0);
        wait_start(10);
        chk("manual start", 32'h1, {31'h0, seen});
        rdreg(ADCSC_OFF_CTRL1);
        chk("busy control", 32'h0, rd);
        repeat (70) @(posedge core_clk);
        rdreg(ADCSC_OFF_CTRL1);
        chk("done set", 32'h1, rd);
        wr(ADCSC_OFF_CTRL1, 32'h2);
        wr(ADCSC_OFF_CTRL1, 32'h0);
        rdreg(ADCSC_OFF_CTRL1);
        chk("done at new start", 32'h0, rd);
        wr(ADCSC_OFF_CTRL1, 32'h0);
        repeat (70) @(posedge core_clk);
        rdreg(ADCSC_OFF_CTRL1);
        chk("done after early clear", 32'h1, rd);
        wr(ADCSC_OFF_CTRL1, 32'h0);
        rdreg(ADCSC_OFF_CTRL1);
        chk("done cleared", 32'h0, rd);
        wr(ADCSC_OFF_CTRL1, 32'h1);
        rdreg(ADCSC_OFF_CTRL1);
        chk("done write one", 32'h0, rd);
        $display("test manual finished");
    endtask
    task automatic t_irq();
        wr(ADCSC_OFF_IRQ_STAT, 32'h3);
        wr(ADCSC_OFF_IRQ_MASK, 32'h1);
        wr(ADCSC_OFF_CTRL1, 32'h2);
        wr(ADCSC_OFF_CTRL1, 32'h0);
        chk("irq while masked start", 32'h0, {31'h0, irq});
        repeat (70) @(posedge core_clk);
        chk("irq raised", 32'h1, {31'h0, irq});
        rdreg(ADCSC_OFF_IRQ_STAT);
        chk("status both", 32'h3, rd);
        wr(ADCSC_OFF_IRQ_STAT, 32'h1);
        repeat (2) @(posedge core_clk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        rdreg(ADCSC_OFF_IRQ_STAT);
        chk("status left", 32'h2, rd);
        wr(ADCSC_OFF_IRQ_MASK, 32'h0);
        $display("test interrupt finished");
    endtask
    task automatic t_trig();
        for (int i = 0; i < 8; i++) begin
            wr(ADCSC_OFF_CTRL1, {24'h0, cd[i][2:0], cd[i][3], 4'h2});
            repeat (3) @(posedge core_clk);
            fire(~(8'h01 << ln[i]));
            wait_start(15);
            chk("foreign trigger", 32'h0, {31'h0, seen});
            fire(8'h01 << ln[i]);
            wait_start(15);
            chk("chosen trigger", 32'h1, {31'h0, seen});
            rdreg(ADCSC_OFF_CTRL1);
            chk("sample cleared", 32'h0, {31'h0, rd[1]});
            repeat (70) @(posedge core_clk);
        end
        $display("test triggers finished");
    endtask
    task automatic t_reserved();
        for (int i = 0; i < 6; i++) begin
            wr(ADCSC_OFF_CTRL1, {24'h0, rsv[i][2:0], rsv[i][3], 4'h2});
            repeat (3) @(posedge core_clk);
            fire(8'hFF);
            wait_start(20);
            chk("reserved start", 32'h0, {31'h0, seen});
            chk("reserved sampling", 32'h1, {31'h0, sampling});
            // A reserved code never ends sampling, so manual mode is chosen first, then used.
            wr(ADCSC_OFF_CTRL1, 32'h2);
            wr(ADCSC_OFF_CTRL1, 32'h0);
            repeat (70) @(posedge core_clk);
        end
        $display("test reserved finished");
    endtask
    task automatic t_auto();
        wr(ADCSC_OFF_CTRL1, 32'hE6);
        base = starts;
        wait_start(25);
        chk("auto early", 32'h0, {31'h0, seen});
        wait_start(25);
        chk("auto start", 32'h1, {31'h0, seen});
        repeat (50) @(posedge core_clk);
        chk("auto resample", 32'h1, {31'h0, sampling});
        rdreg(ADCSC_OFF_CTRL1);
        chk("auto control", 32'hE7, rd);
        // Auto mode is left with a one in the done place, so this write does not clear done.
        wr(ADCSC_OFF_CTRL1, 32'h1);
        repeat (70) @(posedge core_clk);
        $display("test auto finished");
    endtask
    task automatic t_simul(input logic [31:0] c, input logic [3:0] en, input logic [31:0] e);
        wr(ADCSC_OFF_CFG, c);
        wr(ADCSC_OFF_CTRL1, 32'hA);
        repeat (3) @(posedge core_clk);
        chk("channels", {28'h0, en}, {28'h0, ch_en});
        rdreg(ADCSC_OFF_CTRL1);
        chk("simul read", e, rd & 32'hFFFFFFFE);
        wr(ADCSC_OFF_CTRL1, 32'h0);
        repeat (70) @(posedge core_clk);
        $display("test simultaneous finished");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        t_regs();
        t_manual();
        t_irq();
        t_trig();
        t_reserved();
        t_auto();
        t_simul(32'h2, 4'h3, 32'hA);
        t_simul(32'h4, 4'hF, 32'hA);
        t_simul(32'h5, 4'h1, 32'h2);
        t_simul(32'h0, 4'h1, 32'hA);
        give_verdict();
    end
endmodule
